// ---- design/dsp_pkg.sv ----
package dsp_pkg;
    localparam int          CLK_HZ          = 25_000_000;
    localparam int          SCL_HZ          = 100_000;
    // One quarter of a bus bit, the step of the master's bit engine.
    localparam int          SCL_QUARTER_CYC = CLK_HZ / (4 * SCL_HZ);
    localparam logic [6:0]  ADDR_BASE       = 7'h4c;
    localparam int          ADDR_SEL_BIT    = 1;
    localparam int          CTRL_PD_BIT     = 0;
    localparam int          CTRL_BRC_BIT    = 2;
    localparam int          CTRL_LOAD_LO    = 4;
    localparam int          CTRL_LOAD_HI    = 5;
    localparam int          CTRL_SRC_BIT    = 6;
    localparam logic [7:0]  CTRL_ZERO_MASK  = 8'hca;
    localparam logic [7:0]  CTRL_RESET      = 8'h00;
    localparam logic [15:0] DATA_RESET      = 16'h0000;
    localparam int          PD_MODE_LSB     = 5;
    localparam logic [2:0]  PD_MODE_RESET   = 3'h0;
    localparam int          BYTE_BITS       = 8;
    localparam int          FIFO_DEPTH      = 16;

    function automatic logic [6:0] dsp_addr(input logic sel);
        logic [6:0] a;
        a = ADDR_BASE;
        a[ADDR_SEL_BIT] = sel;
        return a;
    endfunction
endpackage

// ---- design/dsp_link_if.sv ----
`timescale 1ns/100ps
interface dsp_link_if;
    logic m_scl_out;
    logic m_scl_oe;
    logic m_sda_out;
    logic m_sda_oe;
    logic s_sda_out;
    logic s_sda_oe;
    logic scl;
    logic sda;

    // Open-drain wires with pull-ups: any enabled low driver wins.
    assign scl = ~(m_scl_oe & ~m_scl_out);
    assign sda = ~((m_sda_oe & ~m_sda_out) | (s_sda_oe & ~s_sda_out));

    modport master (output m_scl_out, m_scl_oe, m_sda_out, m_sda_oe,
                    input  scl, sda);
    modport slave  (output s_sda_out, s_sda_oe,
                    input  scl, sda);
endinterface

// ---- design/dsp_slave.sv ----
`timescale 1ns/100ps
// What this block does
// - Address 1001100, pin replaces bit one.
// - Matched address: pull data low, ninth clock.
// - Master releases data during address acknowledge.
// - Only master starts: data falls, clock high.
// - Master holds data steady while clock high.
// - Write: control byte acknowledged, then high byte.
// - Low byte accepted, MSB first, acknowledged.
// - Further high/low pairs, each a sample.
// - Master ends write with stop or restart.
// - Repeated start returns to address wait.
// - Power-down flag: high byte carries mode bits.
// - Read bit set: acknowledge, then transmit.
// - Read: high data byte first, MSB first.
// - Sample master acknowledge, prepare next byte.
// - Second read byte is low data byte.
// - Third read byte is control byte.
// - Master refuses third byte, then stops.
// - Control byte shows data or temporary source.
// - Convert at fall ending low-byte acknowledge.
// - Stop keeps registers and outputs unchanged.
module dsp_fifo #(
    parameter int W     = 16,
    parameter int DEPTH = 16
) (
    input  wire logic         i_core_clk,
    input  wire logic         i_reset_n,
    input  wire logic         i_in_valid,
    output logic              o_in_ready,
    input  wire logic [W-1:0] i_in_data,
    output logic              o_out_valid,
    input  wire logic         i_out_ready,
    output logic [W-1:0]      o_out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [AW:0]   count;
    } dsp_fifo_s;

    dsp_fifo_s     r;
    dsp_fifo_s     next_r;
    logic [W-1:0]  mem [DEPTH];
    logic          push;
    logic          pop;

    assign o_in_ready  = (r.count != (AW+1)'(DEPTH));
    assign o_out_valid = (r.count != '0);
    assign o_out_data  = mem[r.rptr];
    assign push        = i_in_valid & o_in_ready;
    assign pop         = o_out_valid & i_out_ready;

    always_comb begin
        next_r = r;
        if (push) begin
            next_r.wptr = (r.wptr == AW'(DEPTH - 1)) ? '0 : r.wptr + 1'b1;
        end
        if (pop) begin
            next_r.rptr = (r.rptr == AW'(DEPTH - 1)) ? '0 : r.rptr + 1'b1;
        end
        next_r.count = r.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // The storage has no reset; only the pointers define its contents.
    always_ff @(posedge i_core_clk) begin
        if (push) begin
            mem[r.wptr] <= i_in_data;
        end
    end
endmodule

module dsp_slave
    import dsp_pkg::*;
#(
    parameter int DEPTH = dsp_pkg::FIFO_DEPTH
) (
    input  wire logic   i_core_clk,
    input  wire logic   i_reset_n,
    dsp_link_if.slave   link,
    input  wire logic   i_addr_select_pin,
    output logic        o_sample_valid,
    input  wire logic   i_sample_ready,
    output logic [15:0] o_sample_data,
    output logic        o_convert,
    output logic [7:0]  o_ctrl,
    output logic [15:0] o_data,
    output logic [2:0]  o_power_down_mode
);
    import dsp_pkg::*;

    typedef enum logic [2:0] {
        S_IDLE, S_ADDR, S_AACK, S_RX, S_WACK, S_TX, S_TXACK, S_IGNORE
    } dsp_slave_e;

    typedef struct packed {
        logic [1:0]  scl_s;
        logic [1:0]  sda_s;
        logic [1:0]  pin_s;
        logic        scl_q;
        logic        sda_q;
        dsp_slave_e  st;
        logic [3:0]  cnt;
        logic [7:0]  sh;
        logic [1:0]  idx;
        logic        rw;
        logic        mack;
        logic        sda_low;
        logic [7:0]  ctrl;
        logic [7:0]  temp_hi;
        logic        pending;
        logic [15:0] data;
        logic [2:0]  pd_mode;
        logic        conv;
        logic        push;
    } dsp_slave_s;

    dsp_slave_s r;
    dsp_slave_s next_r;
    logic       fifo_ready;
    logic       rise;
    logic       fall;
    logic       start_c;
    logic       stop_c;

    function automatic logic [7:0] read_byte(input dsp_slave_s s,
                                             input logic [1:0] i);
        logic [7:0] c;
        c = s.ctrl & ~CTRL_ZERO_MASK;
        c[CTRL_SRC_BIT] = s.pending;
        case (i)
            2'h0:    read_byte = s.pending ? s.temp_hi
                                           : s.data[15:8];
            2'h1:    read_byte = s.data[7:0];
            default: read_byte = c;
        endcase
    endfunction

    assign rise    = r.scl_s[1] & ~r.scl_q;
    assign fall    = ~r.scl_s[1] & r.scl_q;
    // Conditions are judged on synchronised copies only.
    assign start_c = r.scl_s[1] & r.scl_q & r.sda_q & ~r.sda_s[1];
    assign stop_c  = r.scl_s[1] & r.scl_q & ~r.sda_q & r.sda_s[1];

    always_comb begin
        next_r       = r;
        next_r.scl_s = {r.scl_s[0], link.scl};
        next_r.sda_s = {r.sda_s[0], link.sda};
        next_r.pin_s = {r.pin_s[0], i_addr_select_pin};
        next_r.scl_q = r.scl_s[1];
        next_r.sda_q = r.sda_s[1];
        next_r.conv  = 1'b0;
        next_r.push  = 1'b0;
        if (start_c) begin
            next_r.st      = S_ADDR;
            next_r.cnt     = 4'h0;
            next_r.sda_low = 1'b0;
        end else if (stop_c) begin
            // Registers are left as they are; only the bus is let go.
            next_r.st      = S_IDLE;
            next_r.sda_low = 1'b0;
        end else begin
            case (r.st)
                S_ADDR, S_RX: begin
                    if (rise) begin
                        next_r.sh  = {r.sh[6:0], r.sda_s[1]};
                        next_r.cnt = r.cnt + 4'h1;
                    end
                    if (fall && r.cnt == 4'(BYTE_BITS)) begin
                        next_r.cnt = 4'h0;
                        if (r.st == S_ADDR) begin
                            if (r.sh[7:1] == dsp_addr(r.pin_s[1])) begin
                                next_r.rw      = r.sh[0];
                                next_r.sda_low = 1'b1;
                                next_r.st      = S_AACK;
                            end else begin
                                next_r.st = S_IGNORE;
                            end
                        end else if (r.idx != 2'h1 || fifo_ready) begin
                            next_r.sda_low = 1'b1;
                            next_r.st      = S_WACK;
                        end else begin
                            // A full sample buffer refuses the new pair.
                            next_r.st = S_IGNORE;
                        end
                    end
                end
                S_AACK: begin
                    if (fall) begin
                        next_r.idx = 2'h0;
                        if (r.rw) begin
                            next_r.sh      = read_byte(r, 2'h0);
                            next_r.sda_low = ~next_r.sh[7];
                            next_r.st      = S_TX;
                        end else begin
                            next_r.sda_low = 1'b0;
                            next_r.st      = S_RX;
                        end
                    end
                end
                S_WACK: begin
                    if (fall) begin
                        next_r.sda_low = 1'b0;
                        next_r.st      = S_RX;
                        case (r.idx)
                            2'h0: begin
                                next_r.ctrl = r.sh;
                                next_r.idx  = 2'h1;
                            end
                            2'h1: begin
                                next_r.temp_hi = r.sh;
                                next_r.pending = 1'b1;
                                next_r.idx     = 2'h2;
                            end
                            default: begin
                                next_r.idx     = 2'h1;
                                next_r.pending = 1'b0;
                                next_r.conv    = 1'b1;
                                if (r.ctrl[CTRL_PD_BIT]) begin
                                    next_r.pd_mode =
                                        r.temp_hi[7:PD_MODE_LSB];
                                end else begin
                                    next_r.data = {r.temp_hi, r.sh};
                                    next_r.push = 1'b1;
                                end
                            end
                        endcase
                    end
                end
                S_TX: begin
                    if (fall) begin
                        next_r.cnt = r.cnt + 4'h1;
                        if (r.cnt == 4'(BYTE_BITS - 1)) begin
                            next_r.sda_low = 1'b0;
                            next_r.st      = S_TXACK;
                        end else begin
                            next_r.sh      = {r.sh[6:0], 1'b0};
                            next_r.sda_low = ~r.sh[6];
                        end
                    end
                end
                S_TXACK: begin
                    if (rise) begin
                        next_r.mack = ~r.sda_s[1];
                    end
                    if (fall) begin
                        next_r.cnt = 4'h0;
                        if (r.mack) begin
                            next_r.idx     = (r.idx == 2'h2) ? 2'h0
                                                             : r.idx + 2'h1;
                            next_r.sh      = read_byte(r, next_r.idx);
                            next_r.sda_low = ~next_r.sh[7];
                            next_r.st      = S_TX;
                        end else begin
                            next_r.st = S_IGNORE;
                        end
                    end
                end
                default: begin
                    next_r.sda_low = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            r         <= '0;
            r.scl_s   <= 2'h3;
            r.sda_s   <= 2'h3;
            r.scl_q   <= 1'b1;
            r.sda_q   <= 1'b1;
            r.st      <= S_IDLE;
            r.ctrl    <= CTRL_RESET;
            r.data    <= DATA_RESET;
            r.pd_mode <= PD_MODE_RESET;
        end else begin
            r <= next_r;
        end
    end

    dsp_fifo #(.W(16), .DEPTH(DEPTH)) u_fifo (
        .i_core_clk  (i_core_clk),
        .i_reset_n   (i_reset_n),
        .i_in_valid  (r.push),
        .o_in_ready  (fifo_ready),
        .i_in_data   (r.data),
        .o_out_valid (o_sample_valid),
        .i_out_ready (i_sample_ready),
        .o_out_data  (o_sample_data)
    );

    assign link.s_sda_out    = 1'b0;
    assign link.s_sda_oe     = r.sda_low;
    assign o_convert         = r.conv;
    assign o_ctrl            = r.ctrl;
    assign o_data            = r.data;
    assign o_power_down_mode = r.pd_mode;
endmodule

// ---- design/dsp_master.sv ----
`timescale 1ns/100ps
module dsp_master
    import dsp_pkg::*;
#(
    parameter int QUARTER = dsp_pkg::SCL_QUARTER_CYC
) (
    input  wire logic        i_core_clk,
    input  wire logic        i_reset_n,
    dsp_link_if.master       link,
    input  wire logic        i_cmd_valid,
    output logic             o_cmd_ready,
    input  wire logic        i_cmd_read,
    input  wire logic        i_cmd_addr_sel,
    input  wire logic [7:0]  i_cmd_ctrl,
    input  wire logic [15:0] i_cmd_data,
    output logic             o_rsp_valid,
    output logic             o_rsp_nack,
    output logic [23:0]      o_rsp_data
);
    import dsp_pkg::*;

    typedef enum logic [2:0] {
        M_IDLE, M_START, M_BIT, M_FIN, M_STOP
    } dsp_master_e;

    typedef struct packed {
        logic [1:0]  sda_s;
        dsp_master_e st;
        logic [15:0] tcnt;
        logic [1:0]  ph;
        logic [3:0]  bitn;
        logic [1:0]  byten;
        logic [7:0]  sh;
        logic        scl_low;
        logic        sda_low;
        logic        read;
        logic        asel;
        logic [7:0]  ctrl;
        logic [15:0] data;
        logic        nack;
        logic [23:0] rd;
        logic        rsp_valid;
    } dsp_master_s;

    dsp_master_s r;
    dsp_master_s next_r;
    logic        tick;
    logic        tx;

    function automatic logic [7:0] tx_byte(input dsp_master_s s,
                                           input logic [1:0] b);
        case (b)
            2'h0:    tx_byte = {dsp_addr(s.asel), s.read};
            2'h1:    tx_byte = s.ctrl;
            2'h2:    tx_byte = s.data[15:8];
            default: tx_byte = s.data[7:0];
        endcase
    endfunction

    assign tick        = (r.tcnt == 16'(QUARTER - 1));
    assign tx          = (r.byten == 2'h0) | ~r.read;
    assign o_cmd_ready = (r.st == M_IDLE) | (r.st == M_FIN);

    always_comb begin
        next_r           = r;
        next_r.sda_s     = {r.sda_s[0], link.sda};
        next_r.tcnt      = tick ? 16'h0 : r.tcnt + 16'h1;
        next_r.rsp_valid = 1'b0;
        if (o_cmd_ready && i_cmd_valid) begin
            next_r.read  = i_cmd_read;
            next_r.asel  = i_cmd_addr_sel;
            next_r.ctrl  = i_cmd_ctrl;
            next_r.data  = i_cmd_data;
            next_r.nack  = 1'b0;
            next_r.st    = M_START;
            next_r.ph    = 2'h0;
        end else if (r.st == M_FIN) begin
            next_r.st = M_STOP;
            next_r.ph = 2'h0;
        end
        if (tick) begin
            next_r.ph = r.ph + 2'h1;
            case (r.st)
                M_START: begin
                    // Also serves as a repeated start from a held bus.
                    case (r.ph)
                        2'h0: next_r.sda_low = 1'b0;
                        2'h1: next_r.scl_low = 1'b0;
                        2'h2: next_r.sda_low = 1'b1;
                        default: begin
                            next_r.scl_low = 1'b1;
                            next_r.st      = M_BIT;
                            next_r.bitn    = 4'h0;
                            next_r.byten   = 2'h0;
                            next_r.sh      = tx_byte(r, 2'h0);
                        end
                    endcase
                end
                M_BIT: begin
                    case (r.ph)
                        2'h0: begin
                            // Data moves only while the clock is low.
                            if (r.bitn == 4'(BYTE_BITS)) begin
                                next_r.sda_low = ~tx &&
                                                 r.byten != 2'h3;
                            end else begin
                                next_r.sda_low = tx & ~r.sh[7];
                            end
                        end
                        2'h1: next_r.scl_low = 1'b0;
                        2'h2: begin
                            if (r.bitn == 4'(BYTE_BITS)) begin
                                if (tx) begin
                                    next_r.nack = r.sda_s[1];
                                end
                            end else if (!tx) begin
                                next_r.sh = {r.sh[6:0], r.sda_s[1]};
                            end
                        end
                        default: begin
                            next_r.scl_low = 1'b1;
                            next_r.bitn    = r.bitn + 4'h1;
                            if (tx && r.bitn != 4'(BYTE_BITS)) begin
                                next_r.sh = {r.sh[6:0], 1'b0};
                            end
                            if (r.bitn == 4'(BYTE_BITS)) begin
                                next_r.bitn  = 4'h0;
                                next_r.byten = r.byten + 2'h1;
                                if (!tx) begin
                                    next_r.rd = {r.rd[15:0], r.sh};
                                end
                                if (r.nack || r.byten == 2'h3) begin
                                    next_r.st        = M_FIN;
                                    next_r.rsp_valid = 1'b1;
                                end else begin
                                    next_r.sh = tx_byte(r, r.byten + 2'h1);
                                end
                            end
                        end
                    endcase
                end
                M_STOP: begin
                    case (r.ph)
                        2'h0: next_r.sda_low = 1'b1;
                        2'h1: next_r.scl_low = 1'b0;
                        2'h2: next_r.sda_low = 1'b0;
                        default: next_r.st = M_IDLE;
                    endcase
                end
                default: begin
                    next_r.ph = 2'h0;
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            r       <= '0;
            r.sda_s <= 2'h3;
            r.st    <= M_IDLE;
        end else begin
            r <= next_r;
        end
    end

    assign link.m_scl_out = 1'b0;
    assign link.m_scl_oe  = r.scl_low;
    assign link.m_sda_out = 1'b0;
    assign link.m_sda_oe  = r.sda_low;
    assign o_rsp_valid    = r.rsp_valid;
    assign o_rsp_nack     = r.nack;
    assign o_rsp_data     = r.rd;
endmodule

// ---- bench/dsp_chk.sv ----
`timescale 1ns/100ps
module dsp_chk (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic m_sda_oe,
    input wire logic s_sda_oe,
    input wire logic scl,
    input wire logic sda,
    input wire logic i_addr_select_pin
);
    logic       scl_q;
    logic       sda_q;
    logic       first;
    logic [3:0] cnt;
    logic [7:0] sr;
    logic       start;
    logic       stop;
    logic       rise;
    logic       ninth;
    logic       hit;

    assign start = scl & scl_q & sda_q & ~sda;
    assign stop  = scl & scl_q & ~sda_q & sda;
    assign rise  = scl & ~scl_q;
    assign ninth = rise & first & (cnt == 4'h8);
    assign hit   = sr[7:1] == {5'h13, i_addr_select_pin, 1'b0};

    // A start clears the bit count, so stray rises before it do no harm.
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            first <= 1'b0;
            cnt   <= 4'h0;
            sr    <= 8'h00;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            if (start) begin
                first <= 1'b1;
                cnt   <= 4'h0;
            end else if (rise && cnt == 4'h8) begin
                first <= 1'b0;
                cnt   <= 4'h0;
            end else if (rise) begin
                sr  <= {sr[6:0], sda};
                cnt <= cnt + 4'h1;
            end
        end
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);

    match_ack_a: assert property (ninth && hit |-> !sda)
    else $error("matching address not acknowledged");
    miss_nack_a: assert property (ninth && !hit |-> sda)
    else $error("foreign address acknowledged");
    addr_quiet_a: assert property (
        rise && first && cnt < 4'h8 |-> !s_sda_oe)
    else $error("slave drove during address bits");
    ack_release_a: assert property (ninth |-> !m_sda_oe)
    else $error("master held data during address ack");
    oe_low_scl_a: assert property (
        $changed(s_sda_oe) |-> !scl)
    else $error("slave changed data while clock high");
    start_free_a: assert property (start |-> !s_sda_oe)
    else $error("slave driving at start");
    stop_free_a: assert property (stop |-> !s_sda_oe)
    else $error("slave driving at stop");
    master_hold_a: assert property (scl && scl_q && $changed(m_sda_oe)
                                    |-> start || stop)
    else $error("master data moved while clock high");

    cover property (ninth && hit);
    cover property (start);
    cover property (stop);
endmodule

// ---- bench/dac_serial_slave_port_tb.sv ----
`timescale 1ns/100ps
module dac_serial_slave_port_tb;
    import dsp_pkg::*;
    typedef struct packed {
        logic        rd;
        logic        sel;
        logic [7:0]  ctrl;
        logic [15:0] data;
        logic        nack;
        logic [23:0] rsp;
    } dsp_row_s;
    localparam dsp_row_s ROWS [8] = '{
        '{1'b0, 1'b0, 8'h30, 16'ha5c3, 1'b0, 24'h000000},
        '{1'b0, 1'b1, 8'h00, 16'h0000, 1'b1, 24'h000000},
        '{1'b1, 1'b0, 8'h00, 16'h0000, 1'b0, 24'ha5c330},
        '{1'b0, 1'b0, 8'h01, 16'ha000, 1'b0, 24'h000000},
        '{1'b1, 1'b0, 8'h00, 16'h0000, 1'b0, 24'ha5c301},
        '{1'b0, 1'b0, 8'h01, 16'h4000, 1'b0, 24'h000000},
        '{1'b0, 1'b0, 8'h00, 16'hffff, 1'b0, 24'h000000},
        '{1'b1, 1'b0, 8'h00, 16'h0000, 1'b0, 24'hffff00}};
    logic i_core_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic cmd_valid = 1'b0;
    logic cmd_read = 1'b0;
    logic cmd_sel = 1'b0;
    logic [7:0] cmd_ctrl = 8'h00;
    logic [15:0] cmd_data = 16'h0000;
    logic pin = 1'b0;
    logic smp_ready = 1'b0;
    logic cmd_ready, rsp_valid, rsp_nack, smp_valid, convert;
    logic [23:0] rsp_data;
    logic [15:0] smp_data, o_data;
    logic [7:0] o_ctrl;
    logic [2:0] pd_mode;
    int miscompares = 0;
    int total_checks = 0;
    int conv = 0;
    int acc;
    logic prev_nack = 1'b0;
    logic [15:0] q[$];

    always #20 i_core_clk = ~i_core_clk;
    // Counted on the falling edge, clear of the edge that moves the pulse.
    always @(negedge i_core_clk) if (convert === 1'b1) conv++;

    dsp_link_if u_dsp_link_if ();
    dsp_master #(.QUARTER(4)) u_dsp_master (.i_core_clk(i_core_clk),
        .i_reset_n(i_reset_n), .link(u_dsp_link_if), .i_cmd_valid(cmd_valid),
        .o_cmd_ready(cmd_ready), .i_cmd_read(cmd_read),
        .i_cmd_addr_sel(cmd_sel), .i_cmd_ctrl(cmd_ctrl),
        .i_cmd_data(cmd_data), .o_rsp_valid(rsp_valid),
        .o_rsp_nack(rsp_nack), .o_rsp_data(rsp_data));
    dsp_slave u_dsp_slave (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
        .link(u_dsp_link_if), .i_addr_select_pin(pin),
        .o_sample_valid(smp_valid), .i_sample_ready(smp_ready),
        .o_sample_data(smp_data), .o_convert(convert), .o_ctrl(o_ctrl),
        .o_data(o_data), .o_power_down_mode(pd_mode));
    dsp_chk u_chk (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
        .m_sda_oe(u_dsp_link_if.m_sda_oe), .s_sda_oe(u_dsp_link_if.s_sda_oe),
        .scl(u_dsp_link_if.scl), .sda(u_dsp_link_if.sda),
        .i_addr_select_pin(pin));

    task automatic chk(input string n, input logic [23:0] e,
                       input logic [23:0] g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    task report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // Returns at the edge that takes the command, so a following call is
    // taken in the finish cycle and makes a repeated start. The nack of the
    // transfer before is kept from the half cycle ahead of that edge.
    task automatic send(input logic rd, input logic sel,
                        input logic [7:0] c, input logic [15:0] d);
        int n;
        @(posedge i_core_clk);
        cmd_valid <= 1'b1;
        cmd_read <= rd;
        cmd_sel <= sel;
        cmd_ctrl <= c;
        cmd_data <= d;
        n = 0;
        do begin
            @(negedge i_core_clk);
            n++;
        end while (cmd_ready !== 1'b1 && n < 3000);
        prev_nack = rsp_nack;
        @(posedge i_core_clk);
        cmd_valid <= 1'b0;
    endtask

    task automatic wait_rsp;
        int n;
        n = 0;
        do begin
            @(negedge i_core_clk);
            n++;
        end while (rsp_valid !== 1'b1 && n < 3000);
    endtask

    initial begin
        repeat (40000) @(posedge i_core_clk);
        miscompares++;
        $display("ERROR watchdog expected done seen hang");
        report_and_stop;
    end

    initial begin
        repeat (3) @(posedge i_core_clk);
        i_reset_n <= 1'b1;
        repeat (4) @(posedge i_core_clk);
        for (int i = 0; i < 8; i++) begin
            send(ROWS[i].rd, ROWS[i].sel, ROWS[i].ctrl, ROWS[i].data);
            wait_rsp;
            // The slave commits a sample a few cycles after the last fall.
            repeat (4) @(negedge i_core_clk);
            chk("nack", 24'(ROWS[i].nack), 24'(rsp_nack));
            if (ROWS[i].rd) begin
                chk("read", ROWS[i].rsp, rsp_data);
            end else if (ROWS[i].ctrl[0]) begin
                chk("pd", 24'(ROWS[i].data[15:13]), 24'(pd_mode));
            end else if (!ROWS[i].nack) begin
                chk("data", 24'(ROWS[i].data), 24'(o_data));
                chk("ctrl", 24'(ROWS[i].ctrl), 24'(o_ctrl));
                q.push_back(ROWS[i].data);
            end
            $display("row %0d done", i);
        end
        @(posedge i_core_clk);
        pin <= 1'b1;
        send(1'b0, 1'b1, 8'h00, 16'h5a5a);
        wait_rsp;
        chk("pin nack", 24'h0, 24'(rsp_nack));
        q.push_back(16'h5a5a);
        $display("pin test done");
        // The sink stalls, so the FIFO must refuse the fourteenth sample.
        acc = 0;
        for (int k = 0; k < 15; k++) begin
            send(1'b0, 1'b1, 8'h00, 16'(16'h1000 + k));
            if (k > 0 && prev_nack === 1'b0) begin
                acc++;
                q.push_back(16'(16'h1000 + k - 1));
            end
        end
        wait_rsp;
        chk("accepted", 24'h00000d, 24'(acc));
        chk("converts", 24'h000012, 24'(conv));
        @(posedge i_core_clk);
        smp_ready <= 1'b1;
        repeat (40) begin
            @(negedge i_core_clk);
            if (smp_valid === 1'b1 && q.size() > 0)
                chk("sample", 24'(q.pop_front()), 24'(smp_data));
        end
        chk("left", 24'h0, 24'(q.size()));
        chk("empty", 24'h0, 24'(smp_valid));
        $display("fifo test done");
        @(posedge i_core_clk);
        i_reset_n <= 1'b0;
        @(negedge i_core_clk);
        chk("reset", 24'h0, {o_ctrl, o_data} | 24'(pd_mode));
        $display("reset test done");
        report_and_stop;
    end
endmodule
